// *** logic/planar_gfx_pkg.sv ***
package planar_gfx_pkg;

   // ---------------------------------------------------------------
   // Host I/O ports
   // ---------------------------------------------------------------
   localparam logic [15:0] INDEX_PORT = 16'h03CE;
   localparam logic [15:0] DATA_PORT  = 16'h03CF;

   // ---------------------------------------------------------------
   // Register indexes
   // ---------------------------------------------------------------
   localparam logic [3:0] IDX_SET_RESET    = 4'h0;
   localparam logic [3:0] IDX_SR_ENABLE    = 4'h1;
   localparam logic [3:0] IDX_COLOR_CMP    = 4'h2;
   localparam logic [3:0] IDX_ROTATE       = 4'h3;
   localparam logic [3:0] IDX_READ_PLANE   = 4'h4;
   localparam logic [3:0] IDX_GFX_MODE     = 4'h5;
   localparam logic [3:0] IDX_MEM_WINDOW   = 4'h6;
   localparam logic [3:0] IDX_CMP_INCLUDE  = 4'h7;
   localparam logic [3:0] IDX_BIT_MASK     = 4'h8;

   // ---------------------------------------------------------------
   // Writable bit masks (reserved bits read zero)
   // ---------------------------------------------------------------
   localparam logic [7:0] MASK_NIBBLE      = 8'h0F;
   localparam logic [7:0] MASK_ROTATE      = 8'h1F;
   localparam logic [7:0] MASK_READ_PLANE  = 8'h03;
   localparam logic [7:0] MASK_GFX_MODE    = 8'h7B;
   localparam logic [7:0] MASK_FULL        = 8'hFF;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int GM_256_COLOR  = 6;
   localparam int GM_SHIFT_MODE = 5;
   localparam int GM_ODD_EVEN   = 4;
   localparam int GM_READ_TYPE  = 3;
   localparam int MW_GRAPHICS   = 0;
   localparam int MW_ODD_EVEN   = 1;
   localparam int MW_MAP_LSB    = 2;
   localparam int RT_FUNC_LSB   = 3;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RESET_ZERO     = 8'h00;
   localparam logic [7:0] RESET_BIT_MASK = 8'hFF;

   // ---------------------------------------------------------------
   // Host address windows (20-bit physical)
   // ---------------------------------------------------------------
   localparam logic [19:0] WIN_A0000 = 20'hA0000;
   localparam logic [19:0] WIN_B0000 = 20'hB0000;
   localparam logic [19:0] WIN_B8000 = 20'hB8000;
   localparam logic [19:0] SPAN_128K = 20'h20000;
   localparam logic [19:0] SPAN_64K  = 20'h10000;
   localparam logic [19:0] SPAN_32K  = 20'h08000;

   typedef enum logic [1:0] {
      FN_PASS = 2'h0,
      FN_AND  = 2'h1,
      FN_OR   = 2'h2,
      FN_XOR  = 2'h3
   } logic_fn_e;

   typedef enum logic [1:0] {
      WM_ROTATE  = 2'h0,
      WM_LATCH   = 2'h1,
      WM_SPREAD  = 2'h2,
      WM_SET_RST = 2'h3
   } write_mode_e;

   typedef enum logic [1:0] {
      SH_PLANAR = 2'h0,
      SH_PAIRED = 2'h1,
      SH_PACKED = 2'h2
   } shift_load_e;

   // Four map bytes carried together
   typedef struct packed {
      logic [7:0] map3;
      logic [7:0] map2;
      logic [7:0] map1;
      logic [7:0] map0;
   } plane_bytes_s;

   // Memory-side write request
   typedef struct packed {
      logic         valid;
      logic [15:0]  addr;
      logic [3:0]   plane_en;
      logic [7:0]   bit_en;
      plane_bytes_s data;
   } plane_write_s;

endpackage

// *** logic/planar_graphics_datapath.sv ***
`timescale 1ns/1ps

module planar_graphics_datapath (
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   // Host I/O cycle, one-cycle strobes
   input  wire logic                       io_wr,
   input  wire logic                       io_rd,
   input  wire logic [15:0]                io_addr,
   input  wire logic [7:0]                 io_wdata,
   output logic [7:0]                      io_rdata,
   // Host memory cycle, one-cycle strobes
   input  wire logic                       mem_wr,
   input  wire logic                       mem_rd,
   input  wire logic [19:0]                mem_addr,
   input  wire logic [7:0]                 mem_wdata,
   output logic [7:0]                      mem_rdata,
   output logic                            mem_hit,
   // Display memory side
   input  wire planar_gfx_pkg::plane_bytes_s plane_rdata,
   output planar_gfx_pkg::plane_write_s      plane_wr,
   output logic [15:0]                     plane_raddr,
   // Sequencer mode bits and shift-register control
   input  wire logic                       seq_chain4,
   output planar_gfx_pkg::shift_load_e       shift_load,
   output logic                            odd_even_addr,
   output logic                            char_latch_en
);

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [3:0] index_reg;
   logic [7:0] set_reset_reg;
   logic [7:0] sr_enable_reg;
   logic [7:0] color_cmp_reg;
   logic [7:0] rotate_reg;
   logic [7:0] read_plane_selector_reg;
   logic [7:0] graphics_mode_control_reg;
   logic [7:0] memory_window_control_reg;
   logic [7:0] compare_plane_include_reg;
   logic [7:0] write_bit_mask_reg;
   planar_gfx_pkg::plane_bytes_s latch_reg;

   wire index_sel = (io_addr == planar_gfx_pkg::INDEX_PORT);
   wire data_sel  = (io_addr == planar_gfx_pkg::DATA_PORT);
   wire data_wr   = io_wr && data_sel;

   // Index decode for data port writes
   wire wr_sr  = data_wr && (index_reg == planar_gfx_pkg::IDX_SET_RESET);
   wire wr_sre = data_wr && (index_reg == planar_gfx_pkg::IDX_SR_ENABLE);
   wire wr_cc  = data_wr && (index_reg == planar_gfx_pkg::IDX_COLOR_CMP);
   wire wr_rot = data_wr && (index_reg == planar_gfx_pkg::IDX_ROTATE);
   wire wr_rps = data_wr && (index_reg == planar_gfx_pkg::IDX_READ_PLANE);
   wire wr_gm  = data_wr && (index_reg == planar_gfx_pkg::IDX_GFX_MODE);
   wire wr_mw  = data_wr && (index_reg == planar_gfx_pkg::IDX_MEM_WINDOW);
   wire wr_cpi = data_wr && (index_reg == planar_gfx_pkg::IDX_CMP_INCLUDE);
   wire wr_bm  = data_wr && (index_reg == planar_gfx_pkg::IDX_BIT_MASK);

   // Register readback; unmapped indexes read zero
   logic [7:0] reg_rdata;
   always_comb begin
      case (index_reg)
         planar_gfx_pkg::IDX_SET_RESET:   reg_rdata = set_reset_reg;
         planar_gfx_pkg::IDX_SR_ENABLE:   reg_rdata = sr_enable_reg;
         planar_gfx_pkg::IDX_COLOR_CMP:   reg_rdata = color_cmp_reg;
         planar_gfx_pkg::IDX_ROTATE:      reg_rdata = rotate_reg;
         planar_gfx_pkg::IDX_READ_PLANE:  reg_rdata = read_plane_selector_reg;
         planar_gfx_pkg::IDX_GFX_MODE:    reg_rdata = graphics_mode_control_reg;
         planar_gfx_pkg::IDX_MEM_WINDOW:  reg_rdata = memory_window_control_reg;
         planar_gfx_pkg::IDX_CMP_INCLUDE: reg_rdata = compare_plane_include_reg;
         planar_gfx_pkg::IDX_BIT_MASK:    reg_rdata = write_bit_mask_reg;
         default:                         reg_rdata = 8'h00;
      endcase
   end

   wire [7:0] io_rdata_next = index_sel ? {4'h0, index_reg} :
                              data_sel  ? reg_rdata : 8'h00;

   // ---------------------------------------------------------------
   // Register writes: reserved bits are masked off on the way in
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         index_reg                 <= 4'h0;
         set_reset_reg             <= planar_gfx_pkg::RESET_ZERO;
         sr_enable_reg             <= planar_gfx_pkg::RESET_ZERO;
         color_cmp_reg             <= planar_gfx_pkg::RESET_ZERO;
         rotate_reg                <= planar_gfx_pkg::RESET_ZERO;
         read_plane_selector_reg   <= planar_gfx_pkg::RESET_ZERO;
         graphics_mode_control_reg <= planar_gfx_pkg::RESET_ZERO;
         memory_window_control_reg <= planar_gfx_pkg::RESET_ZERO;
         compare_plane_include_reg <= planar_gfx_pkg::RESET_ZERO;
         write_bit_mask_reg        <= planar_gfx_pkg::RESET_BIT_MASK;
      end else begin
         if (io_wr && index_sel) index_reg <= io_wdata[3:0];
         if (wr_sr)  set_reset_reg <= io_wdata & planar_gfx_pkg::MASK_NIBBLE;
         if (wr_sre) sr_enable_reg <= io_wdata & planar_gfx_pkg::MASK_NIBBLE;
         if (wr_cc)  color_cmp_reg <= io_wdata & planar_gfx_pkg::MASK_NIBBLE;
         if (wr_rot) rotate_reg <= io_wdata & planar_gfx_pkg::MASK_ROTATE;
         if (wr_rps) read_plane_selector_reg <= io_wdata & planar_gfx_pkg::MASK_READ_PLANE;
         if (wr_gm)  graphics_mode_control_reg <= io_wdata & planar_gfx_pkg::MASK_GFX_MODE;
         if (wr_mw)  memory_window_control_reg <= io_wdata & planar_gfx_pkg::MASK_NIBBLE;
         if (wr_cpi) compare_plane_include_reg <= io_wdata & planar_gfx_pkg::MASK_NIBBLE;
         if (wr_bm)  write_bit_mask_reg <= io_wdata & planar_gfx_pkg::MASK_FULL;
      end
   end

   // ---------------------------------------------------------------
   // Field extraction
   // ---------------------------------------------------------------
   wire [1:0] write_mode   = graphics_mode_control_reg[1:0];
   wire       read_type    = graphics_mode_control_reg[planar_gfx_pkg::GM_READ_TYPE];
   wire       gm_odd_even  = graphics_mode_control_reg[planar_gfx_pkg::GM_ODD_EVEN];
   wire       mw_odd_even  = memory_window_control_reg[planar_gfx_pkg::MW_ODD_EVEN];
   wire       mw_graphics  = memory_window_control_reg[planar_gfx_pkg::MW_GRAPHICS];
   wire [1:0] map_field    = memory_window_control_reg[planar_gfx_pkg::MW_MAP_LSB +: 2];
   wire [2:0] rot_count    = rotate_reg[2:0];
   wire [1:0] func_sel     = rotate_reg[planar_gfx_pkg::RT_FUNC_LSB +: 2];
   wire [1:0] plane_select = read_plane_selector_reg[1:0];

   // ---------------------------------------------------------------
   // Host address window decode
   // ---------------------------------------------------------------
   logic [19:0] win_base;
   logic [19:0] win_span;
   always_comb begin
      case (map_field)
         2'h0:    begin win_base = planar_gfx_pkg::WIN_A0000; win_span = planar_gfx_pkg::SPAN_128K; end
         2'h1:    begin win_base = planar_gfx_pkg::WIN_A0000; win_span = planar_gfx_pkg::SPAN_64K;  end
         2'h2:    begin win_base = planar_gfx_pkg::WIN_B0000; win_span = planar_gfx_pkg::SPAN_32K;  end
         default: begin win_base = planar_gfx_pkg::WIN_B8000; win_span = planar_gfx_pkg::SPAN_32K;  end
      endcase
   end

   wire [19:0] win_off = mem_addr - win_base;
   wire        in_win  = (mem_addr >= win_base) && (win_off < win_span);

   // Odd/even: A0 picks the map pair member, a high bit replaces A0
   wire [15:0] raw_off  = win_off[15:0];
   wire [15:0] map_addr = mw_odd_even ? {raw_off[15:1], win_off[16]} : raw_off;
   wire        odd_sel  = mw_odd_even && raw_off[0];

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   wire [31:0] plane_vec = plane_rdata;

   // Colour compare over the included maps
   logic [7:0] cmp_result;
   always_comb begin
      cmp_result = 8'hFF;
      for (int p = 0; p < 4; p++) begin
         if (compare_plane_include_reg[p])
            cmp_result = cmp_result & ~(plane_vec[p*8 +: 8] ^ {8{color_cmp_reg[p]}});
      end
   end

   // Chain-4 uses the low address bits; odd/even keeps selector pair bit
   wire [1:0] sel_plane = seq_chain4  ? raw_off[1:0] :
                          mw_odd_even ? {plane_select[1], odd_sel} :
                                        plane_select;
   wire [7:0] map_byte  = plane_vec[sel_plane*8 +: 8];
   wire [7:0] mem_rdata_next = read_type ? cmp_result : map_byte;

   // ---------------------------------------------------------------
   // Write path
   // ---------------------------------------------------------------
   // Right rotate by doubling the byte and taking a slice
   wire [15:0] dbl_data = {mem_wdata, mem_wdata};
   wire [7:0]  rot_data = dbl_data[rot_count +: 8];
   wire [31:0] latch_vec = latch_reg;

   logic [31:0] wr_vec;
   logic [7:0]  src;
   logic [7:0]  fn_out;
   logic [7:0]  lat;
   logic [7:0]  mask;
   always_comb begin
      wr_vec = 32'h0;
      src    = 8'h00;
      fn_out = 8'h00;
      lat    = 8'h00;
      // Mode 3 uses rotated data as an extra mask; mode 1 bypasses the mask
      case (write_mode)
         planar_gfx_pkg::WM_SET_RST: mask = rot_data & write_bit_mask_reg;
         planar_gfx_pkg::WM_LATCH:   mask = 8'hFF;
         default:                    mask = write_bit_mask_reg;
      endcase
      for (int p = 0; p < 4; p++) begin
         lat = latch_vec[p*8 +: 8];
         case (write_mode)
            planar_gfx_pkg::WM_ROTATE:  src = sr_enable_reg[p] ? {8{set_reset_reg[p]}} : rot_data;
            planar_gfx_pkg::WM_SPREAD:  src = {8{mem_wdata[p]}};
            planar_gfx_pkg::WM_SET_RST: src = {8{set_reset_reg[p]}};
            default:                    src = lat;
         endcase
         // Logic function follows the rotate, skipped in latch-copy mode
         if (write_mode == planar_gfx_pkg::WM_LATCH) begin
            fn_out = src;
         end else begin
            case (func_sel)
               planar_gfx_pkg::FN_AND: fn_out = src & lat;
               planar_gfx_pkg::FN_OR:  fn_out = src | lat;
               planar_gfx_pkg::FN_XOR: fn_out = src ^ lat;
               default:                fn_out = src;
            endcase
         end
         // Masked-off positions take the latched value back
         wr_vec[p*8 +: 8] = (fn_out & mask) | (lat & ~mask);
      end
   end

   // Odd/even writes reach only the two maps matching A0 parity (0/2 even, 1/3 odd)
   wire [3:0] plane_en_next = mw_odd_even ? (odd_sel ? 4'hA : 4'h5) : 4'hF;

   planar_gfx_pkg::plane_write_s plane_wr_next;
   always_comb begin
      plane_wr_next.valid    = mem_wr && in_win;
      plane_wr_next.addr     = map_addr;
      plane_wr_next.plane_en = plane_en_next;
      plane_wr_next.bit_en   = 8'hFF;
      plane_wr_next.data     = wr_vec;
   end

   // ---------------------------------------------------------------
   // Shift-register load mode
   // ---------------------------------------------------------------
   // 256-colour wins over paired mode
   wire planar_gfx_pkg::shift_load_e shift_load_next =
      graphics_mode_control_reg[planar_gfx_pkg::GM_256_COLOR]  ? planar_gfx_pkg::SH_PACKED :
      graphics_mode_control_reg[planar_gfx_pkg::GM_SHIFT_MODE] ? planar_gfx_pkg::SH_PAIRED :
                                                                 planar_gfx_pkg::SH_PLANAR;

   // ---------------------------------------------------------------
   // Output and latch registers
   // ---------------------------------------------------------------
   // Latches load on each read inside the window; the byte data is
   // expected valid on plane_rdata in the same cycle as mem_rd
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         latch_reg     <= '0;
         io_rdata      <= 8'h00;
         mem_rdata     <= 8'h00;
         mem_hit       <= 1'b0;
         plane_wr      <= '0;
         plane_raddr   <= 16'h0000;
         shift_load    <= planar_gfx_pkg::SH_PLANAR;
         odd_even_addr <= 1'b0;
         char_latch_en <= 1'b1;
      end else begin
         if (mem_rd && in_win) latch_reg <= plane_rdata;
         if (mem_rd && in_win) mem_rdata <= mem_rdata_next;
         if (io_rd) io_rdata <= io_rdata_next;
         mem_hit       <= (mem_rd || mem_wr) && in_win;
         plane_wr      <= plane_wr_next;
         plane_raddr   <= map_addr;
         shift_load    <= shift_load_next;
         odd_even_addr <= gm_odd_even;
         char_latch_en <= ~mw_graphics;
      end
   end

endmodule

// *** sim/planar_graphics_datapath_properties.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port-level checks of the graphics datapath
// ---------------------------------------------------------------
module planar_graphics_datapath_checker (
   input wire logic                         clk,
   input wire logic                         reset_n,
   input wire logic                         io_wr,
   input wire logic                         io_rd,
   input wire logic [7:0]                   io_rdata,
   input wire logic                         mem_wr,
   input wire logic                         mem_rd,
   input wire logic [7:0]                   mem_rdata,
   input wire logic                         mem_hit,
   input wire planar_gfx_pkg::plane_write_s plane_wr,
   input wire planar_gfx_pkg::shift_load_e  shift_load,
   input wire logic                         odd_even_addr,
   input wire logic                         char_latch_en
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Answers on the memory side only ever follow a host strobe
   hit_cause_a: assert property (mem_hit |-> $past(mem_rd || mem_wr))
      else $error("window hit without a memory strobe");
   hit_pulse_a: assert property (mem_hit && !mem_rd && !mem_wr |=> !mem_hit)
      else $error("window hit held longer than one cycle");
   write_cause_a: assert property (plane_wr.valid |-> $past(mem_wr) && mem_hit)
      else $error("map write without a host write in the window");
   // Masking is merged with latch data, so every bit lane is written
   write_lanes_a: assert property (plane_wr.valid |-> plane_wr.bit_en == 8'hFF)
      else $error("map write with partial bit enables");
   rdata_hold_a: assert property (!$past(mem_rd) |-> $stable(mem_rdata))
      else $error("memory read data moved without a read");
   io_hold_a: assert property (!$past(io_rd) |-> $stable(io_rdata))
      else $error("port read data moved without a port read");
   shift_code_a: assert property (shift_load != 2'h3)
      else $error("unknown shift load arrangement");
   // Mode outputs only move after a register write reaches them
   mode_hold_a: assert property (!$past(io_wr) && !$past(io_wr, 2) |-> $stable(odd_even_addr) && $stable(shift_load))
      else $error("mode outputs moved without a register write");
   char_hold_a: assert property (!$past(io_wr) && !$past(io_wr, 2) |-> $stable(char_latch_en))
      else $error("character latch enable moved without a register write");
   cover property (mem_hit && $past(mem_rd));
   cover property (plane_wr.valid);
   cover property (shift_load == planar_gfx_pkg::SH_PACKED);
endmodule

// *** sim/plane_memory_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Display memory model behind the four maps
// ---------------------------------------------------------------
module plane_memory_model (
   input  wire logic                         clk,
   input  wire logic [15:0]                  plane_raddr,
   input  wire planar_gfx_pkg::plane_write_s plane_wr,
   output planar_gfx_pkg::plane_bytes_s      plane_rdata
);
   logic [31:0] cells [256];
   logic [31:0] wdat;
   // Only 256 locations: the bench stays inside the first offsets
   initial for (int i = 0; i < 256; i++) cells[i] = 32'h0;
   assign plane_rdata = cells[plane_raddr[7:0]];
   assign wdat = plane_wr.data;
   // Each enabled map takes its byte lane, bit enables keep the rest
   always @(posedge clk) begin
      if (plane_wr.valid) begin
         for (int p = 0; p < 4; p++) begin
            if (plane_wr.plane_en[p]) begin
               cells[plane_wr.addr[7:0]][p*8 +: 8] <= (cells[plane_wr.addr[7:0]][p*8 +: 8] & ~plane_wr.bit_en)
                                                     | (wdat[p*8 +: 8] & plane_wr.bit_en);
            end
         end
      end
   end
endmodule

// *** sim/test_planar_graphics_datapath.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench top
// ---------------------------------------------------------------
module test_planar_graphics_datapath;
   logic        clk = 1'b0, reset_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
   logic        mem_wr = 1'b0, mem_rd = 1'b0, seq_chain4 = 1'b0, mem_hit, odd_even_addr, char_latch_en;
   logic [15:0] io_addr = 16'h0000, plane_raddr;
   logic [19:0] mem_addr = 20'h00000;
   logic [7:0]  io_wdata = 8'h00, mem_wdata = 8'h00, io_rdata, mem_rdata, lat, ex, dat;
   logic [7:0]  rsv [4] = '{8'h03, 8'h7B, 8'h0F, 8'h0F};
   logic [23:0] ctab [3] = '{24'h0F05FF, 24'h0F0400, 24'h0E04FF};
   logic [19:0] wb [4] = '{20'hA0000, 20'hA0000, 20'hB0000, 20'hB8000};
   logic [19:0] wo [4] = '{20'h9FFFF, 20'hB0000, 20'hB8000, 20'hC0000};
   int          err_count = 0, samples_checked = 0;
   planar_gfx_pkg::plane_bytes_s plane_rdata;
   planar_gfx_pkg::plane_write_s plane_wr;
   planar_gfx_pkg::shift_load_e  shift_load;
   always #4 clk = ~clk;
   planar_graphics_datapath uut (.clk(clk), .reset_n(reset_n), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_hit(mem_hit), .plane_rdata(plane_rdata),
      .plane_wr(plane_wr), .plane_raddr(plane_raddr), .seq_chain4(seq_chain4), .shift_load(shift_load),
      .odd_even_addr(odd_even_addr), .char_latch_en(char_latch_en));
   plane_memory_model mem_model (.clk(clk), .plane_raddr(plane_raddr), .plane_wr(plane_wr),
      .plane_rdata(plane_rdata));
   // ---------------------------------------------------------------
   // Access and compare tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic io_put(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      io_wr <= 1'b1;
      io_addr <= a;
      io_wdata <= d;
      @(posedge clk);
      io_wr <= 1'b0;
   endtask
   task automatic reg_wr(input logic [3:0] i, input logic [7:0] d);
      io_put(planar_gfx_pkg::INDEX_PORT, {4'h0, i});
      io_put(planar_gfx_pkg::DATA_PORT, d);
   endtask
   task automatic reg_rd(input logic [3:0] i, input logic [7:0] exp);
      io_put(planar_gfx_pkg::INDEX_PORT, {4'h0, i});
      @(posedge clk);
      io_rd <= 1'b1;
      io_addr <= planar_gfx_pkg::DATA_PORT;
      @(posedge clk);
      io_rd <= 1'b0;
      #1 check(io_rdata, exp);
   endtask
   // Address goes out a cycle early so the map read address has settled
   task automatic mem_acc(input logic wr, input logic [19:0] a, input logic [7:0] d);
      @(posedge clk);
      mem_addr <= a;
      mem_wdata <= d;
      @(posedge clk);
      mem_rd <= ~wr;
      mem_wr <= wr;
      @(posedge clk);
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      #1;
   endtask
   // Hang guard: a stuck run counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      give_verdict();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      #1 check({7'h0, char_latch_en}, 8'h01);
      reg_rd(planar_gfx_pkg::IDX_BIT_MASK, 8'hFF);
      reg_wr(4'h9, 8'hFF);
      reg_rd(4'h9, 8'h00);
      for (int i = 0; i < 4; i++) begin
         reg_wr(4'h4 + i[3:0], 8'hFF);
         reg_rd(4'h4 + i[3:0], rsv[i]);
      end
      repeat (2) @(posedge clk);
      #1 check({6'h0, shift_load}, 8'h02);
      check({7'h0, odd_even_addr}, 8'h01);
      check({7'h0, char_latch_en}, 8'h00);
      reg_wr(planar_gfx_pkg::IDX_GFX_MODE, 8'h20);
      reg_wr(planar_gfx_pkg::IDX_MEM_WINDOW, 8'h01);
      repeat (2) @(posedge clk);
      #1 check({6'h0, shift_load}, 8'h01);
      check({7'h0, odd_even_addr}, 8'h00);
      // Mode 2 spreads data bits 0..3 over the maps: FF,00,FF,00
      reg_wr(planar_gfx_pkg::IDX_GFX_MODE, 8'h02);
      mem_acc(1'b1, 20'hA0000, 8'h05);
      reg_wr(planar_gfx_pkg::IDX_GFX_MODE, 8'h00);
      for (int i = 0; i < 4; i++) begin
         reg_wr(planar_gfx_pkg::IDX_READ_PLANE, i[7:0]);
         mem_acc(1'b0, 20'hA0000, 8'h00);
         check(mem_rdata, i[0] ? 8'h00 : 8'hFF);
      end
      reg_wr(planar_gfx_pkg::IDX_GFX_MODE, 8'h08);
      for (int i = 0; i < 3; i++) begin
         reg_wr(planar_gfx_pkg::IDX_CMP_INCLUDE, ctab[i][23:16]);
         reg_wr(planar_gfx_pkg::IDX_COLOR_CMP, ctab[i][15:8]);
         mem_acc(1'b0, 20'hA0000, 8'h00);
         check(mem_rdata, ctab[i][7:0]);
      end
      // Selector still points at map 3; chaining must override it
      reg_wr(planar_gfx_pkg::IDX_GFX_MODE, 8'h00);
      seq_chain4 <= 1'b1;
      mem_acc(1'b0, 20'hA0000, 8'h00);
      check(mem_rdata, 8'hFF);
      @(posedge clk);
      seq_chain4 <= 1'b0;
      reg_wr(planar_gfx_pkg::IDX_ROTATE, 8'h01);
      reg_wr(planar_gfx_pkg::IDX_SR_ENABLE, 8'h02);
      reg_wr(planar_gfx_pkg::IDX_SET_RESET, 8'h02);
      mem_acc(1'b1, 20'hA0000, 8'h01);
      for (int i = 0; i < 2; i++) begin
         reg_wr(planar_gfx_pkg::IDX_READ_PLANE, i[7:0]);
         mem_acc(1'b0, 20'hA0000, 8'h00);
         check(mem_rdata, i[0] ? 8'hFF : 8'h80);
      end
      reg_wr(planar_gfx_pkg::IDX_SR_ENABLE, 8'h00);
      reg_wr(planar_gfx_pkg::IDX_BIT_MASK, 8'h3C);
      reg_wr(planar_gfx_pkg::IDX_READ_PLANE, 8'h00);
      lat = 8'h80;
      for (int f = 0; f < 4; f++) begin
         dat = 8'h96 ^ (8'h11 * f[7:0]);
         reg_wr(planar_gfx_pkg::IDX_ROTATE, {3'h0, f[1:0], 3'h0});
         mem_acc(1'b0, 20'hA0000, 8'h00);
         mem_acc(1'b1, 20'hA0000, dat);
         mem_acc(1'b0, 20'hA0000, 8'h00);
         ex = (f == 1) ? dat & lat : (f == 2) ? dat | lat : (f == 3) ? dat ^ lat : dat;
         ex = (ex & 8'h3C) | (lat & 8'hC3);
         check(mem_rdata, ex);
         lat = ex;
      end
      // Mode 3: set/reset byte through a mask built from the host byte
      reg_wr(planar_gfx_pkg::IDX_ROTATE, 8'h00);
      reg_wr(planar_gfx_pkg::IDX_SET_RESET, 8'h01);
      reg_wr(planar_gfx_pkg::IDX_BIT_MASK, 8'hFF);
      reg_wr(planar_gfx_pkg::IDX_GFX_MODE, 8'h03);
      mem_acc(1'b1, 20'hA0000, 8'h0F);
      mem_acc(1'b0, 20'hA0000, 8'h00);
      ex = 8'h0F | (lat & 8'hF0);
      check(mem_rdata, ex);
      reg_wr(planar_gfx_pkg::IDX_GFX_MODE, 8'h01);
      mem_acc(1'b0, 20'hA0000, 8'h00);
      mem_acc(1'b1, 20'hA0001, 8'h00);
      mem_acc(1'b0, 20'hA0001, 8'h00);
      check(mem_rdata, ex);
      for (int m = 0; m < 4; m++) begin
         reg_wr(planar_gfx_pkg::IDX_MEM_WINDOW, {4'h0, m[1:0], 2'h1});
         mem_acc(1'b0, wb[m], 8'h00);
         check({7'h0, mem_hit}, 8'h01);
         mem_acc(1'b0, wo[m], 8'h00);
         check({7'h0, mem_hit}, 8'h00);
      end
      // Odd/even: even byte reaches maps 0/2, odd byte maps 1/3, selector bit 1 picks the pair
      reg_wr(planar_gfx_pkg::IDX_MEM_WINDOW, 8'h03);
      reg_wr(planar_gfx_pkg::IDX_GFX_MODE, 8'h02);
      mem_acc(1'b1, 20'hA0010, 8'h01);
      mem_acc(1'b1, 20'hA0011, 8'h08);
      reg_wr(planar_gfx_pkg::IDX_GFX_MODE, 8'h00);
      for (int k = 0; k < 4; k++) begin
         reg_wr(planar_gfx_pkg::IDX_READ_PLANE, {6'h0, k[1], 1'b0});
         mem_acc(1'b0, {16'hA001, 3'h0, k[0]}, 8'h00);
         check(mem_rdata, (k == 0 || k == 3) ? 8'hFF : 8'h00);
      end
      check({6'h0, shift_load}, 8'h00);
      give_verdict();
   end
endmodule
bind planar_graphics_datapath planar_graphics_datapath_checker checker_inst (.clk(clk), .reset_n(reset_n),
   .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
   .mem_hit(mem_hit), .plane_wr(plane_wr), .shift_load(shift_load), .odd_even_addr(odd_even_addr),
   .char_latch_en(char_latch_en));
